// file: hw/cox_pkg.sv
package cox_pkg;
	typedef enum logic [1:0] {PH_Q1 = 2'h0, PH_Q2 = 2'h1, PH_Q3 = 2'h3, PH_Q4 = 2'h2} cox_phase_t;
	typedef enum logic [2:0] {
		SEQ_NORMAL = 3'h0,
		SEQ_PTR2   = 3'h1,
		SEQ_MOVE2  = 3'h3,
		SEQ_SKIP1  = 3'h2,
		SEQ_SKIP2  = 3'h6
	} cox_seq_t;
	typedef enum logic [3:0] {
		OP_NOP, OP_OR_LIT, OP_OR_REG, OP_MOVE_REG, OP_INC_SKIP, OP_MOVE1, OP_MOVE2,
		OP_PTR1, OP_PTR2, OP_BANK_LIT, OP_MOVE_LIT
	} cox_op_t;
	typedef struct packed {
		cox_op_t     op;
		logic        file_rd;
		logic        wr_w;
		logic        wr_file;
		logic        upd_flags;
		logic        two_word;
		logic        is_w;
		logic [11:0] addr;
	} cox_dec_t;
	// Opcode prefixes
	localparam logic [7:0]  OR_LIT_HI    = 8'h09;
	localparam logic [5:0]  OR_REG_HI    = 6'h04;
	localparam logic [5:0]  MOVE_REG_HI  = 6'h14;
	localparam logic [5:0]  INC_SKIP_HI  = 6'h12;
	localparam logic [3:0]  MOVE_SRC_HI  = 4'hC;
	localparam logic [9:0]  PTR_LOAD_HI  = 10'h3B8;
	localparam logic [7:0]  BANK_LIT_HI  = 8'h01;
	localparam logic [7:0]  MOVE_LIT_HI  = 8'h0E;
	localparam logic [7:0]  JUMP_FAR_HI  = 8'hEF;
	localparam logic [6:0]  CALL_FAR_HI  = 7'h76;
	// Data space layout
	localparam logic [7:0]  ACC_LOW_LAST = 8'h5F;
	localparam logic [3:0]  PAGE_LOW     = 4'h0;
	localparam logic [3:0]  PAGE_HIGH    = 4'hF;
	localparam logic [11:0] W_FILE_ADDR  = 12'hFE8;
	localparam logic [1:0]  PTR_COUNT    = 2'h3;
	localparam logic [1:0]  PTR_INDEXED  = 2'h2;
	localparam logic [3:0]  NIB_ZERO     = 4'h0;
	localparam logic [7:0]  BYTE_ZERO    = 8'h00;
	localparam logic [7:0]  BYTE_ONE     = 8'h01;
	// Software register indices and fields
	localparam logic [3:0]  REG_CTRL     = 4'h0;
	localparam logic [3:0]  REG_WORK     = 4'h1;
	localparam logic [3:0]  REG_BANK     = 4'h2;
	localparam logic [3:0]  REG_STAT     = 4'h3;
	localparam logic [3:0]  REG_PTR0L    = 4'h4;
	localparam logic [3:0]  REG_PTR0H    = 4'h5;
	localparam logic [3:0]  REG_PTR1L    = 4'h6;
	localparam logic [3:0]  REG_PTR1H    = 4'h7;
	localparam logic [3:0]  REG_PTR2L    = 4'h8;
	localparam logic [3:0]  REG_PTR2H    = 4'h9;
	localparam int          CTRL_EXT_BIT = 0;
	localparam int          STAT_Z_BIT   = 0;
	localparam int          STAT_N_BIT   = 1;
endpackage

// file: hw/cox_exec.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module cox_exec (
	input  wire logic        CORE_CLK,
	input  wire logic        RST,
	input  wire logic [15:0] INSTR,
	output logic             INSTR_ACK,
	output logic [11:0]      FILE_ADDR,
	output logic             FILE_RD,
	input  wire logic [7:0]  FILE_RDATA,
	output logic             FILE_WR,
	output logic [7:0]       FILE_WDATA,
	input  wire logic [3:0]  REG_ADDR,
	input  wire logic [7:0]  REG_WDATA,
	input  wire logic        REG_WR,
	input  wire logic        REG_RD,
	output logic [7:0]       REG_RDATA
);
	cox_pkg::cox_phase_t phase_reg;
	cox_pkg::cox_seq_t   seq_reg;
	cox_pkg::cox_dec_t   dec_reg;
	logic [15:0]         ir_reg;
	logic [7:0]          res_reg;
	logic [7:0]          mv_reg;
	logic [7:0]          w_reg;
	logic                flag_n_reg;
	logic                flag_z_reg;
	logic [3:0]          bsr_reg;
	logic [7:0]          ptr_lo_reg [3];
	logic [3:0]          ptr_hi_reg [3];
	logic [1:0]          ptr_sel_reg;
	logic                ctrl_ext_reg;
	logic [7:0]          rdata_reg;
	logic [7:0]          src_now;
	logic [11:0]         ptr2_addr;
	logic [7:0]          rd_next;
	logic                byte_op;

	function automatic logic is_two_word(input logic [15:0] iw);
		is_two_word = (iw[15:12] == cox_pkg::MOVE_SRC_HI) || (iw[15:6] == cox_pkg::PTR_LOAD_HI)
			|| (iw[15:8] == cox_pkg::JUMP_FAR_HI) || (iw[15:9] == cox_pkg::CALL_FAR_HI);
	endfunction

	function automatic logic [11:0] bank_addr(input logic acc, input logic [7:0] f,
			input logic [3:0] bank, input logic [11:0] ptr, input logic ext);
		if (acc) begin
			bank_addr = {bank, f};
		end else if (ext && f <= cox_pkg::ACC_LOW_LAST) begin
			bank_addr = ptr + {cox_pkg::PAGE_LOW, f};
		end else if (f <= cox_pkg::ACC_LOW_LAST) begin
			bank_addr = {cox_pkg::PAGE_LOW, f};
		end else begin
			bank_addr = {cox_pkg::PAGE_HIGH, f};
		end
	endfunction

	function automatic cox_pkg::cox_dec_t decode(input logic [15:0] iw,
			input cox_pkg::cox_seq_t seq, input logic [3:0] bank,
			input logic [11:0] ptr, input logic ext);
		cox_pkg::cox_dec_t d;
		logic              bop;
		d = '0;
		bop = 1'b0;
		d.two_word = is_two_word(iw);
		case (seq)
			cox_pkg::SEQ_NORMAL: begin
				if (iw[15:8] == cox_pkg::OR_LIT_HI) begin
					d.op = cox_pkg::OP_OR_LIT;
				end else if (iw[15:10] == cox_pkg::OR_REG_HI) begin
					d.op = cox_pkg::OP_OR_REG;
					bop = 1'b1;
				end else if (iw[15:10] == cox_pkg::MOVE_REG_HI) begin
					d.op = cox_pkg::OP_MOVE_REG;
					bop = 1'b1;
				end else if (iw[15:10] == cox_pkg::INC_SKIP_HI) begin
					d.op = cox_pkg::OP_INC_SKIP;
					bop = 1'b1;
				end else if (iw[15:12] == cox_pkg::MOVE_SRC_HI) begin
					d.op = cox_pkg::OP_MOVE1;
					d.addr = iw[11:0];
				end else if (iw[15:6] == cox_pkg::PTR_LOAD_HI) begin
					d.op = cox_pkg::OP_PTR1;
				end else if (iw[15:8] == cox_pkg::BANK_LIT_HI) begin
					d.op = cox_pkg::OP_BANK_LIT;
				end else if (iw[15:8] == cox_pkg::MOVE_LIT_HI) begin
					d.op = cox_pkg::OP_MOVE_LIT;
				end
			end
			cox_pkg::SEQ_PTR2: begin
				d.op = cox_pkg::OP_PTR2;
			end
			cox_pkg::SEQ_MOVE2: begin
				d.op = cox_pkg::OP_MOVE2;
				d.addr = iw[11:0];
			end
			default: begin
				d.op = cox_pkg::OP_NOP;
			end
		endcase
		if (bop) begin
			d.addr = bank_addr(iw[8], iw[7:0], bank, ptr, ext);
		end
		// W lives here, so an access to its file address never strobes FILE_RD or FILE_WR
		d.is_w = (bop || d.op == cox_pkg::OP_MOVE1 || d.op == cox_pkg::OP_MOVE2)
			&& d.addr == cox_pkg::W_FILE_ADDR;
		d.file_rd = (bop || d.op == cox_pkg::OP_MOVE1) && !d.is_w;
		d.upd_flags = d.op == cox_pkg::OP_OR_REG || d.op == cox_pkg::OP_MOVE_REG;
		if (bop) begin
			d.wr_w = !iw[9] || d.is_w;
			d.wr_file = iw[9] && !d.is_w;
		end else if (d.op == cox_pkg::OP_MOVE2) begin
			d.wr_w = d.is_w;
			d.wr_file = !d.is_w;
		end else begin
			d.wr_w = d.op == cox_pkg::OP_OR_LIT || d.op == cox_pkg::OP_MOVE_LIT;
		end
		decode = d;
	endfunction

	function automatic logic [7:0] alu(input cox_pkg::cox_op_t op, input logic [7:0] src,
			input logic [7:0] w, input logic [7:0] lit, input logic [7:0] mv);
		case (op)
			cox_pkg::OP_OR_LIT:   alu = w | lit;
			cox_pkg::OP_OR_REG:   alu = w | src;
			cox_pkg::OP_MOVE_REG: alu = src;
			cox_pkg::OP_MOVE1:    alu = src;
			cox_pkg::OP_INC_SKIP: alu = src + cox_pkg::BYTE_ONE;
			cox_pkg::OP_MOVE2:    alu = mv;
			cox_pkg::OP_MOVE_LIT: alu = lit;
			cox_pkg::OP_BANK_LIT: alu = {cox_pkg::NIB_ZERO, lit[3:0]};
			default:              alu = cox_pkg::BYTE_ZERO;
		endcase
	endfunction

	assign ptr2_addr = {ptr_hi_reg[cox_pkg::PTR_INDEXED], ptr_lo_reg[cox_pkg::PTR_INDEXED]};
	assign src_now = dec_reg.is_w ? w_reg : FILE_RDATA;
	assign byte_op = dec_reg.op inside {cox_pkg::OP_OR_REG, cox_pkg::OP_MOVE_REG,
		cox_pkg::OP_INC_SKIP};
	assign INSTR_ACK = phase_reg == cox_pkg::PH_Q1;
	assign FILE_ADDR = dec_reg.addr;
	assign FILE_RD = phase_reg == cox_pkg::PH_Q2 && dec_reg.file_rd;
	assign FILE_WR = phase_reg == cox_pkg::PH_Q4 && dec_reg.wr_file;
	assign FILE_WDATA = res_reg;
	assign REG_RDATA = rdata_reg;

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			phase_reg <= cox_pkg::PH_Q1;
		end else begin
			case (phase_reg)
				cox_pkg::PH_Q1: phase_reg <= cox_pkg::PH_Q2;
				cox_pkg::PH_Q2: phase_reg <= cox_pkg::PH_Q3;
				cox_pkg::PH_Q3: phase_reg <= cox_pkg::PH_Q4;
				default:        phase_reg <= cox_pkg::PH_Q1;
			endcase
		end
	end

	// Decode once per cycle; operands and bank stay frozen until Q4 commits
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ir_reg <= 16'h0000;
			dec_reg <= '0;
		end else if (phase_reg == cox_pkg::PH_Q1) begin
			ir_reg <= INSTR;
			dec_reg <= decode(INSTR, seq_reg, bsr_reg, ptr2_addr, ctrl_ext_reg);
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			res_reg <= cox_pkg::BYTE_ZERO;
			mv_reg <= cox_pkg::BYTE_ZERO;
		end else if (phase_reg == cox_pkg::PH_Q3) begin
			res_reg <= alu(dec_reg.op, src_now, w_reg, ir_reg[7:0], mv_reg);
			if (dec_reg.op == cox_pkg::OP_MOVE1) begin
				mv_reg <= src_now;
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			w_reg <= cox_pkg::BYTE_ZERO;
		end else if (phase_reg == cox_pkg::PH_Q4 && dec_reg.wr_w) begin
			w_reg <= res_reg;
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			flag_n_reg <= 1'b0;
			flag_z_reg <= 1'b0;
		end else if (phase_reg == cox_pkg::PH_Q4 && dec_reg.upd_flags) begin
			flag_n_reg <= res_reg[7];
			flag_z_reg <= res_reg == cox_pkg::BYTE_ZERO;
		end
	end

	// Only the low nibble is stored, so the upper bits cannot become set
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			bsr_reg <= cox_pkg::NIB_ZERO;
		end else if (phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_BANK_LIT) begin
			bsr_reg <= res_reg[3:0];
		end
	end

	// Selector 3 is not a pointer; such a load changes no pointer register
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ptr_sel_reg <= 2'h0;
			for (int i = 0; i < 3; i++) begin
				ptr_lo_reg[i] <= cox_pkg::BYTE_ZERO;
				ptr_hi_reg[i] <= cox_pkg::NIB_ZERO;
			end
		end else if (phase_reg == cox_pkg::PH_Q4) begin
			if (dec_reg.op == cox_pkg::OP_PTR1) begin
				ptr_sel_reg <= ir_reg[5:4];
				if (ir_reg[5:4] < cox_pkg::PTR_COUNT) begin
					ptr_hi_reg[ir_reg[5:4]] <= ir_reg[3:0];
				end
			end else if (dec_reg.op == cox_pkg::OP_PTR2 && ptr_sel_reg < cox_pkg::PTR_COUNT) begin
				ptr_lo_reg[ptr_sel_reg] <= ir_reg[7:0];
			end
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			seq_reg <= cox_pkg::SEQ_NORMAL;
		end else if (phase_reg == cox_pkg::PH_Q4) begin
			case (seq_reg)
				cox_pkg::SEQ_NORMAL: begin
					if (dec_reg.op == cox_pkg::OP_PTR1) begin
						seq_reg <= cox_pkg::SEQ_PTR2;
					end else if (dec_reg.op == cox_pkg::OP_MOVE1) begin
						seq_reg <= cox_pkg::SEQ_MOVE2;
					end else if (dec_reg.op == cox_pkg::OP_INC_SKIP
							&& res_reg != cox_pkg::BYTE_ZERO) begin
						seq_reg <= cox_pkg::SEQ_SKIP1;
					end
				end
				cox_pkg::SEQ_SKIP1: begin
					seq_reg <= dec_reg.two_word ? cox_pkg::SEQ_SKIP2 : cox_pkg::SEQ_NORMAL;
				end
				default: begin
					seq_reg <= cox_pkg::SEQ_NORMAL;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			ctrl_ext_reg <= 1'b0;
		end else if (REG_WR && REG_ADDR == cox_pkg::REG_CTRL) begin
			ctrl_ext_reg <= REG_WDATA[cox_pkg::CTRL_EXT_BIT];
		end
	end

	always_comb begin
		rd_next = cox_pkg::BYTE_ZERO;
		case (REG_ADDR)
			cox_pkg::REG_CTRL:  rd_next[cox_pkg::CTRL_EXT_BIT] = ctrl_ext_reg;
			cox_pkg::REG_WORK:  rd_next = w_reg;
			cox_pkg::REG_BANK:  rd_next = {cox_pkg::NIB_ZERO, bsr_reg};
			cox_pkg::REG_STAT: begin
				rd_next[cox_pkg::STAT_Z_BIT] = flag_z_reg;
				rd_next[cox_pkg::STAT_N_BIT] = flag_n_reg;
			end
			cox_pkg::REG_PTR0L: rd_next = ptr_lo_reg[0];
			cox_pkg::REG_PTR0H: rd_next = {cox_pkg::NIB_ZERO, ptr_hi_reg[0]};
			cox_pkg::REG_PTR1L: rd_next = ptr_lo_reg[1];
			cox_pkg::REG_PTR1H: rd_next = {cox_pkg::NIB_ZERO, ptr_hi_reg[1]};
			cox_pkg::REG_PTR2L: rd_next = ptr_lo_reg[2];
			cox_pkg::REG_PTR2H: rd_next = {cox_pkg::NIB_ZERO, ptr_hi_reg[2]};
			default:            rd_next = cox_pkg::BYTE_ZERO;
		endcase
	end

	// Read data stands for exactly the cycle after the strobe
	always_ff @(posedge CORE_CLK or posedge RST) begin
		if (RST) begin
			rdata_reg <= cox_pkg::BYTE_ZERO;
		end else begin
			rdata_reg <= REG_RD ? rd_next : cox_pkg::BYTE_ZERO;
		end
	end

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);

	property p_or_lit;
		(phase_reg == cox_pkg::PH_Q1 && seq_reg == cox_pkg::SEQ_NORMAL
			&& INSTR[15:8] == cox_pkg::OR_LIT_HI)
		|-> ##4 (w_reg == ($past(w_reg, 4) | $past(INSTR[7:0], 4)));
	endproperty
	a_or_lit: assert property (p_or_lit) else $error("literal OR result wrong");
	property p_or_flags;
		(phase_reg == cox_pkg::PH_Q3 && dec_reg.op == cox_pkg::OP_OR_REG)
		|-> ##2 (flag_z_reg == (($past(w_reg, 2) | $past(src_now, 2)) == cox_pkg::BYTE_ZERO)
			&& flag_n_reg == ($past(w_reg[7], 2) | $past(src_now[7], 2)));
	endproperty
	a_or_flags: assert property (p_or_flags) else $error("register OR flags wrong");
	property p_dest_bit;
		(phase_reg == cox_pkg::PH_Q4 && byte_op && !dec_reg.is_w) |-> (FILE_WR == ir_reg[9]);
	endproperty
	a_dest_bit: assert property (p_dest_bit) else $error("destination select wrong");
	property p_bank_addr;
		(phase_reg == cox_pkg::PH_Q2 && byte_op && ir_reg[8])
		|-> (FILE_ADDR == {bsr_reg, ir_reg[7:0]});
	endproperty
	a_bank_addr: assert property (p_bank_addr) else $error("banked address wrong");
	property p_indexed;
		(phase_reg == cox_pkg::PH_Q2 && byte_op && !ir_reg[8] && $past(ctrl_ext_reg)
			&& ir_reg[7:0] <= cox_pkg::ACC_LOW_LAST)
		|-> (FILE_ADDR == ptr2_addr + {cox_pkg::PAGE_LOW, ir_reg[7:0]});
	endproperty
	a_indexed: assert property (p_indexed) else $error("indexed address wrong");
	property p_ptr_seq;
		(phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_PTR1)
		|=> (seq_reg == cox_pkg::SEQ_PTR2) [*4] ##1 (seq_reg == cox_pkg::SEQ_NORMAL);
	endproperty
	a_ptr_seq: assert property (p_ptr_seq) else $error("pointer load not two cycles");
	property p_move_reg;
		(phase_reg == cox_pkg::PH_Q3 && dec_reg.op == cox_pkg::OP_MOVE_REG && !ir_reg[9])
		|-> ##2 (w_reg == $past(src_now, 2) && flag_n_reg == $past(src_now[7], 2));
	endproperty
	a_move_reg: assert property (p_move_reg) else $error("register move wrong");
	property p_full_move;
		(phase_reg == cox_pkg::PH_Q3 && dec_reg.op == cox_pkg::OP_MOVE1)
		|-> ##5 (phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_MOVE2
			&& (!dec_reg.wr_file || (FILE_WR && FILE_WDATA == $past(src_now, 5))));
	endproperty
	a_full_move: assert property (p_full_move) else $error("full-space move wrong");
	property p_move_w;
		(phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_MOVE2 && dec_reg.is_w)
		|-> (!FILE_WR ##1 w_reg == $past(mv_reg));
	endproperty
	a_move_w: assert property (p_move_w) else $error("move into W wrong");
	property p_bank_lit;
		(phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_BANK_LIT)
		|=> (bsr_reg == $past(ir_reg[3:0]));
	endproperty
	a_bank_lit: assert property (p_bank_lit) else $error("bank load wrong");
	property p_bank_top;
		(REG_RD && REG_ADDR == cox_pkg::REG_BANK)
		|=> (REG_RDATA == {cox_pkg::NIB_ZERO, $past(bsr_reg)});
	endproperty
	a_bank_top: assert property (p_bank_top) else $error("bank upper bits set");
	property p_move_lit;
		(phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_MOVE_LIT)
		|=> (w_reg == $past(ir_reg[7:0]) && $stable(flag_n_reg) && $stable(flag_z_reg));
	endproperty
	a_move_lit: assert property (p_move_lit) else $error("literal move wrong");
	property p_skip_two;
		(phase_reg == cox_pkg::PH_Q4 && seq_reg == cox_pkg::SEQ_SKIP1 && dec_reg.two_word)
		|=> (seq_reg == cox_pkg::SEQ_SKIP2 && !FILE_WR) [*4] ##1 (seq_reg == cox_pkg::SEQ_NORMAL);
	endproperty
	a_skip_two: assert property (p_skip_two) else $error("second word not discarded");

	c_or_lit: cover property (phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_OR_LIT);
	c_move_w: cover property (phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_MOVE2
		&& dec_reg.is_w);
	c_skip_two: cover property (seq_reg == cox_pkg::SEQ_SKIP2);
	c_ptr2: cover property (phase_reg == cox_pkg::PH_Q4 && dec_reg.op == cox_pkg::OP_PTR2);
endmodule

// file: tb/cox_mem_model.sv
`timescale 1ns/1ps
module cox_mem_model (
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic [11:0] file_addr,
	input  wire logic        file_rd,
	output logic [7:0]       file_rdata,
	input  wire logic        file_wr,
	input  wire logic [7:0]  file_wdata
);
	logic [7:0] mem [0:4095];
	// Inverted on every clock without a read, so a stale byte comes back every second clock
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			file_rdata <= 8'h00;
		end else if (file_rd) begin
			file_rdata <= mem[file_addr];
		end else begin
			file_rdata <= ~file_rdata;
		end
	end
	// Plain always: the bench preloads this array by hierarchy
	always @(posedge core_clk) begin
		if (file_wr) begin
			mem[file_addr] <= file_wdata;
		end
	end
endmodule

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        CORE_CLK;
	logic        RST;
	logic [15:0] INSTR;
	logic        INSTR_ACK;
	logic [11:0] FILE_ADDR;
	logic        FILE_RD;
	logic [7:0]  FILE_RDATA;
	logic        FILE_WR;
	logic [7:0]  FILE_WDATA;
	logic [3:0]  REG_ADDR;
	logic [7:0]  REG_WDATA;
	logic        REG_WR;
	logic        REG_RD;
	logic [7:0]  REG_RDATA;
	int          fails;
	int          samples_checked;
	localparam logic [15:0] NOP = 16'h0000;

	cox_exec u_dut (
		.CORE_CLK   (CORE_CLK),
		.RST        (RST),
		.INSTR      (INSTR),
		.INSTR_ACK  (INSTR_ACK),
		.FILE_ADDR  (FILE_ADDR),
		.FILE_RD    (FILE_RD),
		.FILE_RDATA (FILE_RDATA),
		.FILE_WR    (FILE_WR),
		.FILE_WDATA (FILE_WDATA),
		.REG_ADDR   (REG_ADDR),
		.REG_WDATA  (REG_WDATA),
		.REG_WR     (REG_WR),
		.REG_RD     (REG_RD),
		.REG_RDATA  (REG_RDATA)
	);
	cox_mem_model u_mem (
		.core_clk   (CORE_CLK),
		.rst        (RST),
		.file_addr  (FILE_ADDR),
		.file_rd    (FILE_RD),
		.file_rdata (FILE_RDATA),
		.file_wr    (FILE_WR),
		.file_wdata (FILE_WDATA)
	);

	always #25 CORE_CLK = ~CORE_CLK;

	task automatic tally_and_finish;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t byte got %h want %h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD %0t strobe got %b want %b", $time, g, e);
		end
	endtask

	// Entered at the edge that opens Q1; returns at the next such edge
	task automatic slot(input logic [15:0] w, input logic r, input logic wr_s,
		input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
		INSTR <= w;
		REG_RD <= r;
		REG_WR <= wr_s;
		REG_ADDR <= a;
		REG_WDATA <= d;
		#1;
		chk_bit(INSTR_ACK, 1'b1);
		@(posedge CORE_CLK);
		INSTR <= ~w;
		REG_RD <= 1'b0;
		REG_WR <= 1'b0;
		#1;
		chk_bit(INSTR_ACK, 1'b0);
		if (r) chk_byte(REG_RDATA, e);
		@(posedge CORE_CLK);
		#1;
		if (r) chk_byte(REG_RDATA, 8'h00);
		repeat (2) @(posedge CORE_CLK);
	endtask

	task automatic op(input logic [15:0] w);
		slot(w, 1'b0, 1'b0, 4'h0, 8'h00, 8'h00);
	endtask

	// Register accesses ride on a no-op slot to keep the word stream whole
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		slot(NOP, 1'b1, 1'b0, a, 8'h00, e);
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		slot(NOP, 1'b0, 1'b1, a, d, 8'h00);
	endtask

	function automatic logic [15:0] bo(input logic [5:0] p, input logic d, input logic a,
		input logic [7:0] f);
		return {p, d, a, f};
	endfunction

	task automatic idx(input logic [7:0] f, input logic [11:0] a, input logic [7:0] v);
		u_mem.mem[a] = v;
		op(bo(cox_pkg::MOVE_REG_HI, 1'b0, 1'b0, f));
		rd(cox_pkg::REG_WORK, v);
	endtask

	task automatic done(input string s);
		$display("test %0s finished", s);
	endtask

	initial begin
		#200000;
		fails++;
		tally_and_finish;
	end

	initial begin
		CORE_CLK = 1'b0;
		RST = 1'b1;
		INSTR = NOP;
		REG_ADDR = 4'h0;
		REG_WDATA = 8'h00;
		REG_WR = 1'b0;
		REG_RD = 1'b0;
		fails = 0;
		samples_checked = 0;
		repeat (6) @(posedge CORE_CLK);
		RST <= 1'b0;
		wr(cox_pkg::REG_WORK, 8'h55);
		for (int i = 0; i < 16; i++) begin
			rd(i[3:0], 8'h00);
		end
		done("reset");
		op(16'h0E9A);
		rd(cox_pkg::REG_WORK, 8'h9A);
		op(16'h0935);
		rd(cox_pkg::REG_WORK, 8'hBF);
		op(16'h0E91);
		u_mem.mem[12'h020] = 8'h13;
		op(bo(cox_pkg::OR_REG_HI, 1'b0, 1'b0, 8'h20));
		rd(cox_pkg::REG_WORK, 8'h93);
		rd(cox_pkg::REG_STAT, 8'h02);
		chk_byte(u_mem.mem[12'h020], 8'h13);
		op(16'h0105);
		rd(cox_pkg::REG_BANK, 8'h05);
		u_mem.mem[12'h580] = 8'h0F;
		op(bo(cox_pkg::OR_REG_HI, 1'b1, 1'b1, 8'h80));
		rd(cox_pkg::REG_WORK, 8'h93);
		chk_byte(u_mem.mem[12'h580], 8'h9F);
		u_mem.mem[12'hFFF] = 8'h00;
		op(bo(cox_pkg::MOVE_REG_HI, 1'b0, 1'b0, 8'hFF));
		rd(cox_pkg::REG_WORK, 8'h00);
		rd(cox_pkg::REG_STAT, 8'h01);
		op(16'h0E80);
		rd(cox_pkg::REG_STAT, 8'h01);
		op(16'h010F);
		rd(cox_pkg::REG_BANK, 8'h0F);
		op(16'h01A3);
		rd(cox_pkg::REG_BANK, 8'h03);
		done("or and moves");
		op(16'hEE23);
		op(16'hF0AB);
		rd(cox_pkg::REG_PTR2L, 8'hAB);
		rd(cox_pkg::REG_PTR2H, 8'h03);
		op(16'hEE0F);
		op(16'hF0FF);
		rd(cox_pkg::REG_PTR0L, 8'hFF);
		rd(cox_pkg::REG_PTR0H, 8'h0F);
		op(16'hEE15);
		op(16'hF0C4);
		rd(cox_pkg::REG_PTR1L, 8'hC4);
		rd(cox_pkg::REG_PTR1H, 8'h05);
		wr(cox_pkg::REG_CTRL, 8'h01);
		rd(cox_pkg::REG_CTRL, 8'h01);
		idx(8'h05, 12'h3B0, 8'h77);
		idx(8'h5F, 12'h40A, 8'h66);
		idx(8'h60, 12'hF60, 8'h44);
		wr(cox_pkg::REG_CTRL, 8'h00);
		done("pointers");
		u_mem.mem[12'h123] = 8'h33;
		u_mem.mem[12'h456] = 8'h11;
		op(16'hC123);
		chk_byte(u_mem.mem[12'h456], 8'h11);
		op(16'hF456);
		rd(cox_pkg::REG_WORK, 8'h44);
		chk_byte(u_mem.mem[12'h456], 8'h33);
		op(16'h0E5C);
		op(16'hCFE8);
		op(16'hF200);
		rd(cox_pkg::REG_WORK, 8'h5C);
		chk_byte(u_mem.mem[12'h200], 8'h5C);
		u_mem.mem[12'hFE8] = 8'hAA;
		op(16'hC123);
		op(16'hFFE8);
		rd(cox_pkg::REG_WORK, 8'h33);
		chk_byte(u_mem.mem[12'hFE8], 8'hAA);
		done("full move");
		u_mem.mem[12'h030] = 8'h10;
		u_mem.mem[12'h500] = 8'h00;
		op(bo(cox_pkg::INC_SKIP_HI, 1'b1, 1'b0, 8'h30));
		op(16'hC123);
		op(16'hF500);
		op(16'h0E77);
		rd(cox_pkg::REG_WORK, 8'h77);
		chk_byte(u_mem.mem[12'h500], 8'h00);
		chk_byte(u_mem.mem[12'h030], 8'h11);
		u_mem.mem[12'h031] = 8'hFF;
		op(bo(cox_pkg::INC_SKIP_HI, 1'b1, 1'b0, 8'h31));
		op(16'h0E42);
		rd(cox_pkg::REG_WORK, 8'h42);
		chk_byte(u_mem.mem[12'h031], 8'h00);
		done("skip");
		tally_and_finish;
	end
endmodule
